// File: design/ascc_core.sv
// register front end, baud generator, line routing and parity for the serial core
`timescale 1ns/1ps
// Summary of operation
// - status_one ignores writes, reserved bits read zero.
// - baud_high bit 7 enables the infrared submodule, clear bypasses it.
// - narrow pulse code 11=1/4, 10=1/32, 01=1/16, 00=3/16 bit time.
// - divisor top five bits in baud_high 4:0, low eight in baud_low.
// - infrared off, bit rate is clock over sixteen times full divisor.
// - infrared on, bit rate is clock over thirty-two times divisor 12:1.
// - baud_high write is held until baud_low is written.
// - baud generator stays stopped until tx or rx enable first set.
// - baud generator off while the divisor bits in use are all zero.
// - loopback cuts the receive pin and feeds receiver from transmitter.
// - loopback with source 0 loopback_select inside, source 1 is single wire.
// - doze halt bit stops the module during processor wait mode.
// - nine-bit bit selects nine data bits, clear selects eight.
// - wakeup bit picks idle line or address mark wakeup.
// - idle origin bit starts idle count after start or after stop.
// - parity enabled puts parity in the top data bit and checks it.
// - parity odd select 0 gives even parity, 1 gives odd parity.
// - eight registers decoded at offsets 0 through 7.
// - tx enable hands the transmit pin to the module, rx enable starts rx.
// - halted transfers freeze during wait and resume after; reset aborts.
module ascc_core
  import ascc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // processor power state
  input wire logic cpu_wait,
  // transfer logic side
  input wire logic tx_serial,
  input wire logic [8:0] rx_char,
  input wire logic [7:0] status_one_in,
  output logic [8:0] tx_char,
  output logic tx_data_write,
  output logic rx_data_read,
  output logic sample_tick,
  output logic rx_line,
  output logic tx_parity_bit,
  output logic rx_parity_error,
  output logic module_halted,
  // configuration to the transfer logic
  output logic infrared_enable,
  output logic [3:0] pulse_width_32nds,
  output logic [1:0] narrow_pulse_select,
  output logic loopback_select,
  output logic rx_source_select,
  output logic nine_bit_frame,
  output logic wake_address_mark,
  output logic idle_count_origin,
  output logic parity_enable,
  output logic parity_odd_select,
  output logic tx_enable,
  output logic rx_enable,
  output logic [4:0] status_two_ctrl,
  // serial pins
  input wire logic rxd_in,
  input wire logic txd_in,
  output logic txd_out,
  output logic txd_oe
);

  logic [7:0] high_hold_q, high_hold_d;
  logic [7:0] high_live_q, high_live_d;
  logic [7:0] low_q, low_d;
  logic [7:0] ctrl1_q, ctrl1_d;
  logic [7:0] ctrl2_q, ctrl2_d;
  logic [4:0] stat2_q, stat2_d;
  logic tx_ninth_q, tx_ninth_d;
  logic [7:0] tx_low_q, tx_low_d;
  logic [7:0] rdata_q, rdata_d;
  logic started_q, started_d;
  logic [12:0] cnt_q, cnt_d;
  logic [12:0] divisor;
  logic [12:0] period;
  logic wr_high, wr_low, gen_run;
  logic rxd_meta_q, rxd_sync_q, txd_meta_q, txd_sync_q;

  // register write decode
  assign wr_high = reg_write && (reg_addr == ADDR_BAUD_HIGH);
  assign wr_low = reg_write && (reg_addr == ADDR_BAUD_LOW);

  // register next values; status_one is read only so writes to it vanish
  always_comb begin
    high_hold_d = high_hold_q;
    high_live_d = high_live_q;
    low_d = low_q;
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    stat2_d = stat2_q;
    tx_ninth_d = tx_ninth_q;
    tx_low_d = tx_low_q;
    if (wr_high) begin
      high_hold_d = reg_wdata;
    end
    if (wr_low) begin
      low_d = reg_wdata;
      high_live_d = high_hold_q;
    end
    if (reg_write) begin
      unique case (reg_addr)
        ADDR_CONTROL_ONE: ctrl1_d = reg_wdata;
        ADDR_CONTROL_TWO: ctrl2_d = reg_wdata;
        ADDR_STATUS_TWO: stat2_d = reg_wdata[STAT2_W-1:0];
        ADDR_DATA_HIGH: tx_ninth_d = reg_wdata[BIT_TX_NINTH];
        ADDR_DATA_LOW: tx_low_d = reg_wdata;
        default: ctrl1_d = ctrl1_q;
      endcase
    end
  end

  // read mux; the answer is registered so it stands one cycle after the strobe
  always_comb begin
    rdata_d = rdata_q;
    if (reg_read) begin
      unique case (reg_addr)
        ADDR_BAUD_HIGH: rdata_d = high_live_q;
        ADDR_BAUD_LOW: rdata_d = low_q;
        ADDR_CONTROL_ONE: rdata_d = ctrl1_q;
        ADDR_CONTROL_TWO: rdata_d = ctrl2_q;
        ADDR_STATUS_ONE: rdata_d = status_one_in;
        ADDR_STATUS_TWO: rdata_d = {3'h0, stat2_q};
        ADDR_DATA_HIGH: rdata_d = {rx_char[8], tx_ninth_q, 6'h00};
        ADDR_DATA_LOW: rdata_d = rx_char[7:0];
        default: rdata_d = RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      high_hold_q <= RESET_BYTE;
      high_live_q <= RESET_BYTE;
      low_q <= RESET_BYTE;
      ctrl1_q <= RESET_BYTE;
      ctrl2_q <= RESET_BYTE;
      stat2_q <= RESET_BYTE[STAT2_W-1:0];
      tx_ninth_q <= 1'b0;
      tx_low_q <= RESET_BYTE;
      rdata_q <= RESET_BYTE;
    end else begin
      high_hold_q <= high_hold_d;
      high_live_q <= high_live_d;
      low_q <= low_d;
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      stat2_q <= stat2_d;
      tx_ninth_q <= tx_ninth_d;
      tx_low_q <= tx_low_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign tx_char = {tx_ninth_q, tx_low_q};
  assign tx_data_write = reg_write && (reg_addr == ADDR_DATA_LOW);
  assign rx_data_read = reg_read && (reg_addr == ADDR_DATA_LOW);

  // configuration fields out of the live registers
  assign infrared_enable = high_live_q[BIT_INFRARED];
  assign narrow_pulse_select = high_live_q[BIT_PULSE_HI:BIT_PULSE_LO];
  assign divisor = {high_live_q[BIT_DIV_TOP:0], low_q};
  assign loopback_select = ctrl1_q[BIT_LOOPBACK];
  assign rx_source_select = ctrl1_q[BIT_RX_SOURCE];
  assign nine_bit_frame = ctrl1_q[BIT_NINE_BITS];
  assign wake_address_mark = ctrl1_q[BIT_WAKE_ADDR];
  assign idle_count_origin = ctrl1_q[BIT_IDLE_ORIGIN];
  assign parity_enable = ctrl1_q[BIT_PARITY_EN];
  assign parity_odd_select = ctrl1_q[BIT_PARITY_ODD];
  assign tx_enable = ctrl2_q[BIT_TX_ENABLE];
  assign rx_enable = ctrl2_q[BIT_RX_ENABLE];
  assign status_two_ctrl = stat2_q;

  // infrared pulse width in 1/32 bit time; the transmitter scales it by period
  always_comb begin
    unique case (narrow_pulse_select)
      PULSE_QUARTER: pulse_width_32nds = WIDTH_QUARTER;
      PULSE_THIRTYSECOND: pulse_width_32nds = WIDTH_THIRTYSECOND;
      PULSE_SIXTEENTH: pulse_width_32nds = WIDTH_SIXTEENTH;
      PULSE_THREE_SIXTEENTHS: pulse_width_32nds = WIDTH_THREE_SIXTEENTHS;
    endcase
  end

  // tick period in clocks for the 16x sample rate; in infrared mode bit 0
  // is dropped and the rest doubled, so clk/(32*div[12:1]) falls out the same
  assign period = infrared_enable ? {divisor[12:1], 1'b0} : divisor;

  // wait mode with doze halt freezes the generator; state is kept for resume
  assign module_halted = ctrl1_q[BIT_DOZE_HALT] && cpu_wait;
  assign gen_run = started_q && (period != RESET_DIV) && !module_halted;

  // baud counter; a divisor commit reloads so the next period is the new one
  always_comb begin
    started_d = started_q || tx_enable || rx_enable;
    cnt_d = cnt_q;
    sample_tick = 1'b0;
    if (wr_low) begin
      // the staged infrared bit decides the new period; the live copy changes this edge
      cnt_d = high_hold_q[BIT_INFRARED] ? {high_hold_q[BIT_DIV_TOP:0], reg_wdata[7:1], 1'b0} :
                                {high_hold_q[BIT_DIV_TOP:0], reg_wdata};
    end else if (gen_run) begin
      if (cnt_q <= DIV_ONE) begin
        sample_tick = 1'b1;
        cnt_d = period;
      end else begin
        cnt_d = cnt_q - DIV_ONE;
      end
    end
  end

  // reset_n is the only way out of wait by reset, so it aborts the count
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      started_q <= 1'b0;
      cnt_q <= RESET_DIV;
    end else begin
      started_q <= started_d;
      cnt_q <= cnt_d;
    end
  end

  // pin synchronisers; only the second stage is read
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rxd_meta_q <= 1'b1;
      rxd_sync_q <= 1'b1;
      txd_meta_q <= 1'b1;
      txd_sync_q <= 1'b1;
    end else begin
      rxd_meta_q <= rxd_in;
      rxd_sync_q <= rxd_meta_q;
      txd_meta_q <= txd_in;
      txd_sync_q <= txd_meta_q;
    end
  end

  // receive source; the route follows loopback_select and rx_source_select alone, whatever the enables
  always_comb begin
    if (!loopback_select) begin
      rx_line = rxd_sync_q;
    end else if (rx_source_select) begin
      rx_line = txd_sync_q;
    end else begin
      rx_line = tx_serial;
    end
  end

  // transmit pin is released whenever the transmitter is off; idles high
  assign txd_oe = tx_enable;
  assign txd_out = tx_enable ? tx_serial : 1'b1;

  // parity over the bits below the parity slot: 7 in 8-bit, 8 in 9-bit frames
  logic [8:0] data_mask;
  assign data_mask = nine_bit_frame ? 9'h0ff : 9'h07f;
  assign tx_parity_bit = (^(tx_char & data_mask)) ^ parity_odd_select;
  assign rx_parity_error = parity_enable &&
    ((^(rx_char & {nine_bit_frame, 1'b1, 7'h7f})) != parity_odd_select);

  // helper: clocks since the last tick or reload, checked against period
  logic [12:0] gap_q;
  logic clean_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gap_q <= RESET_DIV;
      clean_q <= 1'b0;
    end else if (sample_tick || wr_low) begin
      gap_q <= DIV_ONE;
      clean_q <= sample_tick;
    end else if (gen_run) begin
      gap_q <= gap_q + DIV_ONE;
    end else begin
      clean_q <= 1'b0;
    end
  end

  // properties watch what this block drives, some of them against the stimulus itself (reg_wdata, tx_serial)
  a_reserved_zero: assert property (@(posedge clock) disable iff (!reset_n)
    reg_read && reg_addr == ADDR_STATUS_TWO |=> reg_rdata[7:STAT2_W] == 3'h0)
    else $error("reserved status bits read nonzero");

  a_data_high_zero: assert property (@(posedge clock) disable iff (!reset_n)
    reg_read && reg_addr == ADDR_DATA_HIGH |=> reg_rdata[5:0] == 6'h00)
    else $error("reserved data high bits read nonzero");

  a_read_latency: assert property (@(posedge clock) disable iff (!reset_n)
    reg_read && reg_addr == ADDR_CONTROL_ONE |=> reg_rdata == $past(ctrl1_q))
    else $error("control one read data not one cycle late");

  a_high_staged: assert property (@(posedge clock) disable iff (!reset_n)
    wr_high && !wr_low |=> $stable(high_live_q))
    else $error("baud high took effect before low write");

  a_divisor_commit: assert property (@(posedge clock) disable iff (!reset_n)
    wr_low |=> divisor == {$past(high_hold_q[4:0]), $past(reg_wdata)})
    else $error("divisor not assembled from hold and low byte");

  a_commit_reload: assert property (@(posedge clock) disable iff (!reset_n)
    wr_low |=> cnt_q == period)
    else $error("baud counter not reloaded with the new period");

  a_gen_stopped: assert property (@(posedge clock) disable iff (!reset_n)
    !started_q |-> !sample_tick)
    else $error("baud tick before first enable");

  a_zero_divisor: assert property (@(posedge clock) disable iff (!reset_n)
    (infrared_enable ? divisor[12:1] == 12'h000 : divisor == RESET_DIV)
    |-> !sample_tick)
    else $error("baud tick with zero divisor");

  a_tick_period: assert property (@(posedge clock) disable iff (!reset_n)
    sample_tick && clean_q && $stable(period) |-> gap_q == period)
    else $error("tick spacing differs from divisor");

  a_halt_freeze: assert property (@(posedge clock) disable iff (!reset_n)
    module_halted && !wr_low |=> $stable(cnt_q) && !$past(sample_tick))
    else $error("baud counter moved in wait mode");

  a_halt_no_tick: assert property (@(posedge clock) disable iff (!reset_n)
    module_halted |-> !sample_tick)
    else $error("baud tick while halted in wait mode");

  a_normal_route: assert property (@(posedge clock) disable iff (!reset_n)
    !loopback_select |-> rx_line == rxd_sync_q)
    else $error("receiver not fed from the receive pin");

  a_loop_route: assert property (@(posedge clock) disable iff (!reset_n)
    loopback_select && !rx_source_select |-> rx_line == tx_serial)
    else $error("internal loop not routed");

  a_single_wire: assert property (@(posedge clock) disable iff (!reset_n)
    loopback_select && rx_source_select |-> rx_line == txd_sync_q)
    else $error("single wire not fed from the transmit pin");

  a_pin_release: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(tx_enable) |-> !txd_oe && txd_out)
    else $error("transmit pin driven while disabled");

  a_pin_idle: assert property (@(posedge clock) disable iff (!reset_n)
    !tx_enable |-> !txd_oe && txd_out)
    else $error("transmit pin not released while disabled");

  a_pulse_quarter: assert property (@(posedge clock) disable iff (!reset_n)
    narrow_pulse_select == 2'h3 |-> pulse_width_32nds == 4'h8)
    else $error("quarter pulse width wrong");

  a_parity_even: assert property (@(posedge clock) disable iff (!reset_n)
    !parity_odd_select && !nine_bit_frame |-> tx_parity_bit == ^tx_char[6:0])
    else $error("even parity bit wrong");

  a_parity_nine: assert property (@(posedge clock) disable iff (!reset_n)
    nine_bit_frame && !parity_odd_select |-> tx_parity_bit == ^tx_char[7:0])
    else $error("nine bit even parity bit wrong");

  a_parity_off: assert property (@(posedge clock) disable iff (!reset_n)
    !parity_enable |-> !rx_parity_error)
    else $error("parity error flagged with parity disabled");

  c_tick: cover property (@(posedge clock) disable iff (!reset_n) sample_tick ##[1:20] sample_tick);
  c_commit: cover property (@(posedge clock) disable iff (!reset_n) wr_high ##[1:5] wr_low);
  c_single_wire: cover property (@(posedge clock) disable iff (!reset_n)
    loopback_select && rx_source_select && tx_enable && rx_enable);
  c_halted: cover property (@(posedge clock) disable iff (!reset_n) gen_run ##1 module_halted);
  c_ir_tick: cover property (@(posedge clock) disable iff (!reset_n) infrared_enable && sample_tick);

endmodule : ascc_core

// File: design/ascc_pkg.sv
// shared constants for the serial configuration core
package ascc_pkg;
  // register offsets
  localparam logic [2:0] ADDR_BAUD_HIGH = 3'h0;
  localparam logic [2:0] ADDR_BAUD_LOW = 3'h1;
  localparam logic [2:0] ADDR_CONTROL_ONE = 3'h2;
  localparam logic [2:0] ADDR_CONTROL_TWO = 3'h3;
  localparam logic [2:0] ADDR_STATUS_ONE = 3'h4;
  localparam logic [2:0] ADDR_STATUS_TWO = 3'h5;
  localparam logic [2:0] ADDR_DATA_HIGH = 3'h6;
  localparam logic [2:0] ADDR_DATA_LOW = 3'h7;
  // baud_high fields
  localparam int BIT_INFRARED = 7;
  localparam int BIT_PULSE_HI = 6;
  localparam int BIT_PULSE_LO = 5;
  localparam int BIT_DIV_TOP = 4;
  // control_one fields
  localparam int BIT_LOOPBACK = 7;
  localparam int BIT_DOZE_HALT = 6;
  localparam int BIT_RX_SOURCE = 5;
  localparam int BIT_NINE_BITS = 4;
  localparam int BIT_WAKE_ADDR = 3;
  localparam int BIT_IDLE_ORIGIN = 2;
  localparam int BIT_PARITY_EN = 1;
  localparam int BIT_PARITY_ODD = 0;
  // control_two fields
  localparam int BIT_TX_ENABLE = 3;
  localparam int BIT_RX_ENABLE = 2;
  // data_high fields
  localparam int BIT_RX_NINTH = 7;
  localparam int BIT_TX_NINTH = 6;
  // widths
  localparam int DIV_W = 13;
  localparam int STAT2_W = 5;
  // reset values and the counter step
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [12:0] RESET_DIV = 13'h0000;
  localparam logic [12:0] DIV_ONE = 13'h0001;
  // narrow pulse codes and widths in 1/32 of a bit time
  localparam logic [1:0] PULSE_QUARTER = 2'h3;
  localparam logic [1:0] PULSE_THIRTYSECOND = 2'h2;
  localparam logic [1:0] PULSE_SIXTEENTH = 2'h1;
  localparam logic [1:0] PULSE_THREE_SIXTEENTHS = 2'h0;
  localparam logic [3:0] WIDTH_QUARTER = 4'h8;
  localparam logic [3:0] WIDTH_THIRTYSECOND = 4'h1;
  localparam logic [3:0] WIDTH_SIXTEENTH = 4'h2;
  localparam logic [3:0] WIDTH_THREE_SIXTEENTHS = 4'h6;
endpackage : ascc_pkg

// File: dv/ascc_far_end.sv
// behavioural remote serial device on the far side of the two pins
`timescale 1ns/1ps
module ascc_far_end (
  // pins seen from the remote side
  input wire logic txd_out,
  input wire logic txd_oe,
  // level the remote puts on its own output
  input wire logic far_bit,
  output logic rxd_wire,
  output logic txd_wire
);
  // the receive pin carries whatever the remote sends; idle is high
  assign rxd_wire = far_bit;
  // shared transmit wire: the core wins while it drives, else the remote's level
  assign txd_wire = txd_oe ? txd_out : far_bit;
endmodule : ascc_far_end

// File: dv/tb_top.sv
// self-checking bench for the serial configuration core
`timescale 1ns/1ps
module tb_top;
  import ascc_pkg::*;
  logic clock = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, status_one_in = 8'h5a;
  logic cpu_wait = 1'b0, tx_serial = 1'b1, far_bit = 1'b1, rxd_w, txd_w;
  logic [8:0] rx_char = 9'h1a5, tx_char;
  logic sample_tick, rx_line, tx_parity_bit, rx_parity_error, module_halted;
  logic infrared_enable, loopback_select, rx_source_select, nine_bit_frame;
  logic wake_address_mark, idle_count_origin, parity_enable, parity_odd_select;
  logic tx_enable, rx_enable, txd_out, txd_oe;
  logic [3:0] pulse_width_32nds;
  logic [1:0] narrow_pulse_select;
  logic [4:0] status_two_ctrl;
  int n_mismatch = 0, checks = 0, cycles = 0;
  logic [3:0] widths [4] = '{WIDTH_THREE_SIXTEENTHS, WIDTH_SIXTEENTH, WIDTH_THIRTYSECOND,
                             WIDTH_QUARTER};
  ascc_core i_dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .cpu_wait(cpu_wait), .tx_serial(tx_serial), .rx_char(rx_char),
    .status_one_in(status_one_in), .tx_char(tx_char), .tx_data_write(), .rx_data_read(),
    .sample_tick(sample_tick), .rx_line(rx_line), .tx_parity_bit(tx_parity_bit),
    .rx_parity_error(rx_parity_error), .module_halted(module_halted),
    .infrared_enable(infrared_enable), .pulse_width_32nds(pulse_width_32nds),
    .narrow_pulse_select(narrow_pulse_select), .loopback_select(loopback_select),
    .rx_source_select(rx_source_select), .nine_bit_frame(nine_bit_frame),
    .wake_address_mark(wake_address_mark), .idle_count_origin(idle_count_origin),
    .parity_enable(parity_enable), .parity_odd_select(parity_odd_select),
    .tx_enable(tx_enable), .rx_enable(rx_enable), .status_two_ctrl(status_two_ctrl),
    .rxd_in(rxd_w), .txd_in(txd_w), .txd_out(txd_out), .txd_oe(txd_oe));
  ascc_far_end i_far (.txd_out(txd_out), .txd_oe(txd_oe), .far_bit(far_bit),
    .rxd_wire(rxd_w), .txd_wire(txd_w));
  // free-running clock, 25 ns period
  initial begin
    forever #12.5 clock = ~clock;
  end
  // hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch = n_mismatch + 1;
      final_report();
    end
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write strobe beside address and data
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
    // step off the edge so callers see the registers the write has just updated
    #1;
  endtask : wr
  // read data stand from the cycle after the strobe is taken until the next read
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk({1'b0, d}, {1'b0, exp});
  endtask : rd_chk
  // counts ticks over a window; a window that is a multiple of the period is phase-free
  task automatic ticks(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clock);
      #1 if (sample_tick === 1'b1) c = c + 1;
    end
  endtask : ticks
  task automatic tick_chk(input int n, input int exp);
    int c;
    ticks(n, c);
    chk(c[8:0], exp[8:0]);
  endtask : tick_chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    // reset state and read map, reserved parts read zero
    chk({7'h00, txd_oe, txd_out}, 9'h001);
    for (int a = 0; a < 8; a++) begin
      rd_chk(a[2:0], (a == 4) ? 8'h5a : (a == 6) ? 8'h80 : (a == 7) ? 8'ha5 : 8'h00);
    end
    wr(ADDR_STATUS_ONE, 8'hff);
    rd_chk(ADDR_STATUS_ONE, 8'h5a);
    wr(ADDR_STATUS_TWO, 8'hff);
    rd_chk(ADDR_STATUS_TWO, 8'h1f);
    chk({4'h0, status_two_ctrl}, 9'h01f);
    wr(ADDR_DATA_HIGH, 8'hff);
    rd_chk(ADDR_DATA_HIGH, 8'hc0);
    $display("test register map done");
    // staged high byte only goes live with the low byte
    wr(ADDR_BAUD_HIGH, 8'h80);
    rd_chk(ADDR_BAUD_HIGH, 8'h00);
    chk({8'h00, infrared_enable}, 9'h000);
    wr(ADDR_BAUD_LOW, 8'h05);
    rd_chk(ADDR_BAUD_HIGH, 8'h80);
    rd_chk(ADDR_BAUD_LOW, 8'h05);
    chk({8'h00, infrared_enable}, 9'h001);
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_BAUD_HIGH, {1'b1, p[1:0], 5'h00});
      wr(ADDR_BAUD_LOW, 8'h05);
      chk({5'h00, pulse_width_32nds}, {5'h00, widths[p]});
      chk({7'h00, narrow_pulse_select}, {7'h00, p[1:0]});
    end
    $display("test staged baud done");
    // no ticks until an enable has been set once
    tick_chk(40, 0);
    wr(ADDR_CONTROL_TWO, 8'h04);
    chk({7'h00, rx_enable, tx_enable}, 9'h002);
    wr(ADDR_CONTROL_TWO, 8'h00);
    tick_chk(40, 10);
    wr(ADDR_BAUD_HIGH, 8'h01);
    wr(ADDR_BAUD_LOW, 8'h03);
    // divisor 0x103: the first period after the reload is the full new one
    tick_chk(257, 0);
    tick_chk(2 * 259, 2);
    wr(ADDR_BAUD_HIGH, 8'h80);
    wr(ADDR_BAUD_LOW, 8'h01);
    tick_chk(60, 0);
    wr(ADDR_BAUD_HIGH, 8'h00);
    wr(ADDR_BAUD_LOW, 8'h00);
    tick_chk(60, 0);
    wr(ADDR_BAUD_LOW, 8'h03);
    $display("test baud generator done");
    // doze halt stops ticks only while the processor waits
    wr(ADDR_CONTROL_ONE, 8'h40);
    cpu_wait <= 1'b1;
    tick_chk(30, 0);
    chk({8'h00, module_halted}, 9'h001);
    cpu_wait <= 1'b0;
    tick_chk(30, 10);
    cpu_wait <= 1'b1;
    wr(ADDR_CONTROL_ONE, 8'h00);
    tick_chk(30, 10);
    cpu_wait <= 1'b0;
    $display("test wait halt done");
    // line routing: normal, internal loop, single wire
    wr(ADDR_CONTROL_TWO, 8'h0c);
    far_bit <= 1'b0;
    repeat (4) @(posedge clock);
    #1 chk({8'h00, rx_line}, 9'h000);
    wr(ADDR_CONTROL_ONE, 8'h80);
    tx_serial <= 1'b1;
    repeat (4) @(posedge clock);
    #1 chk({8'h00, rx_line}, 9'h001);
    tx_serial <= 1'b0;
    @(posedge clock);
    #1 chk({7'h00, rx_line, txd_out}, 9'h000);
    far_bit <= 1'b1;
    wr(ADDR_CONTROL_ONE, 8'ha0);
    repeat (4) @(posedge clock);
    #1 chk({8'h00, rx_line}, 9'h000);
    chk({7'h00, loopback_select, rx_source_select}, 9'h003);
    tx_serial <= 1'b1;
    $display("test loop routing done");
    // frame options and parity
    wr(ADDR_CONTROL_ONE, 8'h1c);
    chk({6'h00, nine_bit_frame, wake_address_mark, idle_count_origin}, 9'h007);
    wr(ADDR_CONTROL_ONE, 8'h03);
    wr(ADDR_DATA_LOW, 8'h87);
    chk(tx_char, 9'h187);
    chk({7'h00, parity_enable, tx_parity_bit}, 9'h002);
    rx_char <= 9'h081;
    #1 chk({8'h00, rx_parity_error}, 9'h001);
    wr(ADDR_CONTROL_ONE, 8'h02);
    chk({8'h00, tx_parity_bit}, 9'h001);
    chk({8'h00, rx_parity_error}, 9'h000);
    wr(ADDR_CONTROL_ONE, 8'h12);
    chk({8'h00, tx_parity_bit}, 9'h000);
    $display("test parity done");
    // a reset in mid-run clears the map and stops the generator again
    reset_n <= 1'b0;
    @(posedge clock);
    reset_n <= 1'b1;
    rd_chk(ADDR_CONTROL_ONE, 8'h00);
    chk({7'h00, txd_oe, txd_out}, 9'h001);
    tick_chk(40, 0);
    $display("test reset abort done");
    final_report();
  end
endmodule : tb_top
